// ===== inc/ccr_pkg.sv
/*
  charger configuration register bank: offsets, field positions, reset values.
  assumes a byte-wide register port with an 8-bit address.
*/
package ccr_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_BATT_REG_VOLTAGE   = 8'h0c;
  localparam logic [7:0] OFS_FAST_CHARGE_CTRL   = 8'h0d;
  localparam logic [7:0] OFS_CHARGER_CTRL_FIRST = 8'h0e;
  localparam logic [7:0] OFS_CHARGER_CTRL_SEC   = 8'h0f;
  localparam logic [7:0] OFS_CHIP_GENERAL_CTRL  = 8'h10;
  localparam logic [7:0] OFS_SOFT_RESET_CTRL    = 8'h12;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_BATT_REG_VOLTAGE   = 8'h46;
  localparam logic [7:0] RST_FAST_CHARGE_CTRL   = 8'h05;
  localparam logic [7:0] RST_CHARGER_CTRL_FIRST = 8'h70;
  localparam logic [7:0] RST_CHARGER_CTRL_SEC   = 8'h45;
  localparam logic [7:0] RST_CHIP_GENERAL_CTRL  = 8'h10;
  // ---------------------------------------------------------------
  // writable bit masks, reserved bits clear
  // ---------------------------------------------------------------
  localparam logic [7:0] WMASK_BATT_REG_VOLTAGE = 8'h7f;
  localparam logic [7:0] WMASK_CHIP_GENERAL     = 8'h7f;
  // watchdog-restored bits per register
  localparam logic [7:0] WDOG_MASK_FAST_CHARGE  = 8'h80;
  localparam logic [7:0] WDOG_MASK_CTRL_FIRST   = 8'h30;
  localparam logic [7:0] WDOG_MASK_CHIP_GENERAL = 8'h0c;
  // bits not restored by software reset (precharge voltage select)
  localparam logic [7:0] SWRST_KEEP_CHIP_GENERAL = 8'h40;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BIT_CHARGE_INHIBIT      = 7;
  localparam int BIT_PRECHARGE_RATIO     = 6;
  localparam int LSB_TERMINATION_RATIO   = 4;
  localparam int LSB_DISCHARGE_LIMIT     = 6;
  localparam int LSB_DEPLETION_THRESHOLD = 3;
  localparam int BIT_SHORT_TRICKLE       = 2;
  localparam int LSB_SEQUENCE_DELAY      = 0;
  localparam int BIT_SOFT_RESET          = 7;
  // ---------------------------------------------------------------
  // voltage code limit and current mapping
  // ---------------------------------------------------------------
  localparam logic [6:0]  VREG_CODE_MAX       = 7'h73;
  localparam logic [12:0] VREG_BASE_MV        = 13'd3500;
  localparam logic [12:0] VREG_STEP_MV        = 13'd10;
  localparam logic [6:0]  FAST_CHARGE_CURRENT_CODE_LOW_CODE_MAX   = 7'd30;
  localparam logic [10:0] FAST_CHARGE_CURRENT_CODE_LOW_OFFSET_MA  = 11'd5;
  localparam logic [10:0] FAST_CHARGE_CURRENT_CODE_HIGH_BASE_MA   = 11'd40;
  localparam logic [6:0]  FAST_CHARGE_CURRENT_CODE_HIGH_BASE_CODE = 7'd31;
  localparam logic [10:0] FAST_CHARGE_CURRENT_CODE_STEP_MA        = 11'd10;
endpackage

// ===== inc/ccr_map_if.sv
/*
  interface carrying the voltage and current codes and their mV and mA values between the register
  bank and its mapping unit. assumes one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
interface ccr_map_if;
  logic [6:0]  volt_code;
  logic [6:0]  curr_code;
  logic [12:0] volt_mv;
  logic [10:0] curr_ma;
  modport bank (output volt_code, output curr_code, input volt_mv, input curr_ma);
  modport map  (input volt_code, input curr_code, output volt_mv, output curr_ma);
endinterface
`default_nettype wire

// ===== src/ccr_map.sv
/*
  combinational mapping of voltage and current codes to millivolts and
  milliamps. assumes codes come from registered fields.
*/
`timescale 1ns/1ps
`default_nettype none
module ccr_map
  import ccr_pkg::*;
(
  ccr_map_if.map m
);
  logic [6:0] clamped;
  always_comb begin
    // clamp above top code
    clamped   = (m.volt_code > VREG_CODE_MAX) ? VREG_CODE_MAX : m.volt_code;
    m.volt_mv = VREG_BASE_MV + 13'(clamped) * VREG_STEP_MV;
    // two-segment current map
    if (m.curr_code <= FAST_CHARGE_CURRENT_CODE_LOW_CODE_MAX) begin
      m.curr_ma = 11'(m.curr_code) + FAST_CHARGE_CURRENT_CODE_LOW_OFFSET_MA;
    end else begin
      m.curr_ma = FAST_CHARGE_CURRENT_CODE_HIGH_BASE_MA + 11'(m.curr_code - FAST_CHARGE_CURRENT_CODE_HIGH_BASE_CODE) * FAST_CHARGE_CURRENT_CODE_STEP_MA;
    end
  end
endmodule
`default_nettype wire

// ===== src/ccr_bank.sv
/*
  charger configuration register bank with software reset and watchdog
  restore, plus decoded settings outputs.
  assumes a synchronous byte register port driven by a host interface.
*/
`timescale 1ns/1ps
`default_nettype none
module ccr_bank
  import ccr_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  // register port
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  // watchdog expiry pulse
  input  wire logic        watchdog_expired,
  // decoded settings
  output logic [6:0]       batt_reg_voltage_code,
  output logic [12:0]      batt_reg_voltage_mv,
  output logic [6:0]       fast_charge_current_code,
  output logic [10:0]      fast_charge_current_ma,
  output logic             charge_inhibit,
  output logic             precharge_ratio_sel,
  output logic [1:0]       termination_ratio_sel,
  output logic [1:0]       discharge_limit_sel,
  output logic [2:0]       depletion_threshold_sel,
  output logic             short_trickle_current_sel,
  output logic [1:0]       sequence_delay_sel,
  output logic [7:0]       chip_general_ctrl
);
  // ---------------------------------------------------------------
  // reset synchroniser
  // ---------------------------------------------------------------
  logic rst_meta;
  logic rst_sync_n;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic [7:0] batt_reg_voltage;
  logic [7:0] fast_charge_current_control;
  logic [7:0] charger_control_first;
  logic [7:0] charger_control_second;
  logic [7:0] chip_general_control;
  logic [7:0] next_batt_reg_voltage;
  logic [7:0] next_fast_charge_current_control;
  logic [7:0] next_charger_control_first;
  logic [7:0] next_charger_control_second;
  logic [7:0] next_chip_general_control;
  logic       soft_reset;

  assign soft_reset = reg_wr && (reg_addr == OFS_SOFT_RESET_CTRL) && reg_wdata[BIT_SOFT_RESET];

  always_comb begin
    next_batt_reg_voltage            = batt_reg_voltage;
    next_fast_charge_current_control = fast_charge_current_control;
    next_charger_control_first       = charger_control_first;
    next_charger_control_second      = charger_control_second;
    next_chip_general_control        = chip_general_control;
    if (soft_reset) begin
      // restore software-reset fields
      next_batt_reg_voltage            = RST_BATT_REG_VOLTAGE;
      next_fast_charge_current_control = RST_FAST_CHARGE_CTRL;
      next_charger_control_first       = RST_CHARGER_CTRL_FIRST;
      next_charger_control_second      = RST_CHARGER_CTRL_SEC;
      next_chip_general_control        = (chip_general_control & SWRST_KEEP_CHIP_GENERAL)
                                       | (RST_CHIP_GENERAL_CTRL & ~SWRST_KEEP_CHIP_GENERAL);
    end else begin
      if (reg_wr) begin
        case (reg_addr)
          OFS_BATT_REG_VOLTAGE: begin
            next_batt_reg_voltage = reg_wdata & WMASK_BATT_REG_VOLTAGE;
          end
          OFS_FAST_CHARGE_CTRL: begin
            next_fast_charge_current_control = reg_wdata;
          end
          OFS_CHARGER_CTRL_FIRST: begin
            next_charger_control_first = reg_wdata;
          end
          OFS_CHARGER_CTRL_SEC: begin
            next_charger_control_second = reg_wdata;
          end
          OFS_CHIP_GENERAL_CTRL: begin
            next_chip_general_control = reg_wdata & WMASK_CHIP_GENERAL;
          end
          default: begin
          end
        endcase
      end
      if (watchdog_expired) begin
        // watchdog restore wins over a same-cycle write
        next_fast_charge_current_control = (next_fast_charge_current_control & ~WDOG_MASK_FAST_CHARGE)
                                         | (RST_FAST_CHARGE_CTRL & WDOG_MASK_FAST_CHARGE);
        next_charger_control_first       = (next_charger_control_first & ~WDOG_MASK_CTRL_FIRST)
                                         | (RST_CHARGER_CTRL_FIRST & WDOG_MASK_CTRL_FIRST);
        next_chip_general_control        = (next_chip_general_control & ~WDOG_MASK_CHIP_GENERAL)
                                         | (RST_CHIP_GENERAL_CTRL & WDOG_MASK_CHIP_GENERAL);
      end
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      batt_reg_voltage            <= RST_BATT_REG_VOLTAGE;
      fast_charge_current_control <= RST_FAST_CHARGE_CTRL;
      charger_control_first       <= RST_CHARGER_CTRL_FIRST;
      charger_control_second      <= RST_CHARGER_CTRL_SEC;
      chip_general_control        <= RST_CHIP_GENERAL_CTRL;
    end else begin
      batt_reg_voltage            <= next_batt_reg_voltage;
      fast_charge_current_control <= next_fast_charge_current_control;
      charger_control_first       <= next_charger_control_first;
      charger_control_second      <= next_charger_control_second;
      chip_general_control        <= next_chip_general_control;
    end
  end

  // ---------------------------------------------------------------
  // code mapping
  // ---------------------------------------------------------------
  ccr_map_if map_bus ();
  assign map_bus.volt_code = batt_reg_voltage[6:0];
  assign map_bus.curr_code = fast_charge_current_control[6:0];
  ccr_map u_map (
    .m (map_bus.map)
  );

  // ---------------------------------------------------------------
  // read data and decoded outputs, registered
  // ---------------------------------------------------------------
  logic [7:0]  next_reg_rdata;
  logic [12:0] next_volt_mv;
  logic [10:0] next_curr_ma;
  always_comb begin
    next_reg_rdata = reg_rdata;
    if (reg_rd) begin
      case (reg_addr)
        OFS_BATT_REG_VOLTAGE:   next_reg_rdata = batt_reg_voltage & WMASK_BATT_REG_VOLTAGE;
        OFS_FAST_CHARGE_CTRL:   next_reg_rdata = fast_charge_current_control;
        OFS_CHARGER_CTRL_FIRST: next_reg_rdata = charger_control_first;
        OFS_CHARGER_CTRL_SEC:   next_reg_rdata = charger_control_second;
        OFS_CHIP_GENERAL_CTRL:  next_reg_rdata = chip_general_control & WMASK_CHIP_GENERAL;
        default:                next_reg_rdata = 8'h00;
      endcase
    end
    next_volt_mv = map_bus.volt_mv;
    next_curr_ma = map_bus.curr_ma;
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reg_rdata                 <= 8'h00;
      batt_reg_voltage_code     <= 7'h00;
      batt_reg_voltage_mv       <= 13'h0000;
      fast_charge_current_code  <= 7'h00;
      fast_charge_current_ma    <= 11'h000;
      charge_inhibit            <= 1'b0;
      precharge_ratio_sel       <= 1'b0;
      termination_ratio_sel     <= 2'h0;
      discharge_limit_sel       <= 2'h0;
      depletion_threshold_sel   <= 3'h0;
      short_trickle_current_sel <= 1'b0;
      sequence_delay_sel        <= 2'h0;
      chip_general_ctrl         <= 8'h00;
    end else begin
      reg_rdata                 <= next_reg_rdata;
      batt_reg_voltage_code     <= batt_reg_voltage[6:0];
      batt_reg_voltage_mv       <= next_volt_mv;
      fast_charge_current_code  <= fast_charge_current_control[6:0];
      fast_charge_current_ma    <= next_curr_ma;
      charge_inhibit            <= fast_charge_current_control[BIT_CHARGE_INHIBIT];
      precharge_ratio_sel       <= charger_control_first[BIT_PRECHARGE_RATIO];
      termination_ratio_sel     <= charger_control_first[LSB_TERMINATION_RATIO +: 2];
      discharge_limit_sel       <= charger_control_second[LSB_DISCHARGE_LIMIT +: 2];
      depletion_threshold_sel   <= charger_control_second[LSB_DEPLETION_THRESHOLD +: 3];
      short_trickle_current_sel <= charger_control_second[BIT_SHORT_TRICKLE];
      sequence_delay_sel        <= charger_control_second[LSB_SEQUENCE_DELAY +: 2];
      chip_general_ctrl         <= chip_general_control & WMASK_CHIP_GENERAL;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_volt_clamp: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (batt_reg_voltage[6:0] > VREG_CODE_MAX) |=> (batt_reg_voltage_mv == 13'd4650))
    else $error("voltage not clamped");
  chk_volt_reserved: assert property (@(posedge clock) disable iff (!rst_sync_n)
    !batt_reg_voltage[7])
    else $error("reserved voltage bit set");
  chk_curr_low_map: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (fast_charge_current_control[6:0] == 7'd30) |=> (fast_charge_current_ma == 11'd35))
    else $error("low current map wrong");
  chk_curr_high_map: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (fast_charge_current_control[6:0] == 7'd32) |=> (fast_charge_current_ma == 11'd50))
    else $error("high current map wrong");
  chk_soft_reset_restore: assert property (@(posedge clock) disable iff (!rst_sync_n)
    soft_reset |=> (batt_reg_voltage == RST_BATT_REG_VOLTAGE && fast_charge_current_control == RST_FAST_CHARGE_CTRL
                    && charger_control_second == RST_CHARGER_CTRL_SEC) ##1 (charge_inhibit == 1'b0))
    else $error("soft reset did not restore");
  chk_wdog_inhibit: assert property (@(posedge clock) disable iff (!rst_sync_n)
    watchdog_expired |=> !fast_charge_current_control[BIT_CHARGE_INHIBIT])
    else $error("watchdog left inhibit set");
  chk_wdog_term: assert property (@(posedge clock) disable iff (!rst_sync_n)
    watchdog_expired |=> ##1 (termination_ratio_sel == 2'h3))
    else $error("watchdog left termination");
  chk_write_field: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (reg_wr && !soft_reset && reg_addr == OFS_CHARGER_CTRL_SEC) |=> ##1
      (discharge_limit_sel == $past(reg_wdata[7:6], 2) && sequence_delay_sel == $past(reg_wdata[1:0], 2)))
    else $error("second control write lost");
  chk_read_reserved: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (reg_rd && reg_addr == OFS_BATT_REG_VOLTAGE) |=> !reg_rdata[7])
    else $error("reserved read nonzero");
endmodule
`default_nettype wire

// ===== tb/charger_config_registers_tb.sv
/*
  self-checking bench for the charger configuration register bank.
  assumes ccr_pkg and ccr_bank compiled first; drives the register port directly.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH %s expected %0h seen %0h", what, e, g); end end
module charger_config_registers_tb
  import ccr_pkg::*;
;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        clock;
  logic        reset_n;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic        watchdog_expired;
  logic [6:0]  batt_reg_voltage_code;
  logic [12:0] batt_reg_voltage_mv;
  logic [6:0]  fast_charge_current_code;
  logic [10:0] fast_charge_current_ma;
  logic        charge_inhibit;
  logic        precharge_ratio_sel;
  logic [1:0]  termination_ratio_sel;
  logic [1:0]  discharge_limit_sel;
  logic [2:0]  depletion_threshold_sel;
  logic        short_trickle_current_sel;
  logic [1:0]  sequence_delay_sel;
  logic [7:0]  chip_general_ctrl;
  logic [7:0]  shadow [5];
  integer      seed;
  int          bad_count;
  int          n_compared;
  int          cycles;

  ccr_bank u_dut (.clock(clock), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .watchdog_expired(watchdog_expired),
    .batt_reg_voltage_code(batt_reg_voltage_code), .batt_reg_voltage_mv(batt_reg_voltage_mv),
    .fast_charge_current_code(fast_charge_current_code), .fast_charge_current_ma(fast_charge_current_ma),
    .charge_inhibit(charge_inhibit), .precharge_ratio_sel(precharge_ratio_sel),
    .termination_ratio_sel(termination_ratio_sel), .discharge_limit_sel(discharge_limit_sel),
    .depletion_threshold_sel(depletion_threshold_sel), .short_trickle_current_sel(short_trickle_current_sel),
    .sequence_delay_sel(sequence_delay_sel), .chip_general_ctrl(chip_general_ctrl));

  // ---------------------------------------------------------------
  // clock and timeout
  // ---------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      results();
    end
  end

  // ---------------------------------------------------------------
  // expectation helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] rst_val(int i);
    case (i)
      0: return 8'h46;
      1: return 8'h05;
      2: return 8'h70;
      3: return 8'h45;
      default: return 8'h10;
    endcase
  endfunction
  function automatic logic [12:0] exp_mv(logic [6:0] c);
    return (c > 7'h73) ? 13'd4650 : 13'd3500 + 13'(c) * 13'd10;
  endfunction
  function automatic logic [10:0] exp_ma(logic [6:0] c);
    return (c <= 7'd30) ? 11'(c) + 11'd5 : 11'd40 + (11'(c) - 11'd31) * 11'd10;
  endfunction
  function automatic logic [7:0] exp_rd(logic [7:0] a);
    return (a >= 8'h0c && a <= 8'h10) ? shadow[a - 8'h0c] : 8'h00;
  endfunction

  // ---------------------------------------------------------------
  // bus tasks
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] keep;
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    if (a == 8'h0c || a == 8'h10) shadow[a - 8'h0c] = d & 8'h7f;
    else if (a >= 8'h0d && a <= 8'h0f) shadow[a - 8'h0c] = d;
    else if (a == 8'h12 && d[7]) begin
      keep = shadow[4] & 8'h40;
      for (int i = 0; i < 5; i++) shadow[i] = rst_val(i);
      shadow[4] = (shadow[4] & 8'hbf) | keep;
    end
  endtask
  task automatic rd_chk(input logic [7:0] a);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    #1;
    `CHK("reg_rdata", exp_rd(a), reg_rdata)
  endtask
  task automatic wdog();
    @(posedge clock);
    watchdog_expired <= 1'b1;
    @(posedge clock);
    watchdog_expired <= 1'b0;
    shadow[1] = shadow[1] & 8'h7f;
    shadow[2] = shadow[2] | 8'h30;
    shadow[4] = shadow[4] & 8'hf3;
  endtask
  task automatic chk_fields();
    repeat (3) @(posedge clock);
    #1;
    `CHK("volt_code", shadow[0][6:0], batt_reg_voltage_code)
    `CHK("volt_mv", exp_mv(shadow[0][6:0]), batt_reg_voltage_mv)
    `CHK("curr_code", shadow[1][6:0], fast_charge_current_code)
    `CHK("curr_ma", exp_ma(shadow[1][6:0]), fast_charge_current_ma)
    `CHK("inhibit", shadow[1][7], charge_inhibit)
    `CHK("prechg", shadow[2][6], precharge_ratio_sel)
    `CHK("term", shadow[2][5:4], termination_ratio_sel)
    `CHK("dischg", shadow[3][7:6], discharge_limit_sel)
    `CHK("depl", shadow[3][5:3], depletion_threshold_sel)
    `CHK("trickle", shadow[3][2], short_trickle_current_sel)
    `CHK("seqdly", shadow[3][1:0], sequence_delay_sel)
    `CHK("general", shadow[4], chip_general_ctrl)
  endtask
  task automatic all_regs();
    for (int a = 12; a <= 18; a++) rd_chk(8'(a));
    chk_fields();
  endtask
  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [7:0] a;
    logic [7:0] d;
    reset_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    watchdog_expired = 1'b0;
    seed = 32'hf098a050;
    for (int i = 0; i < 5; i++) shadow[i] = rst_val(i);
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    repeat (5) @(posedge clock);
    all_regs();
    $display("test reset_values done");
    wr(8'h0c, 8'h73);
    chk_fields();
    wr(8'h0c, 8'h74);
    chk_fields();
    wr(8'h0c, 8'hff);
    rd_chk(8'h0c);
    chk_fields();
    for (int c = 29; c <= 32; c++) begin
      wr(8'h0d, 8'(c));
      chk_fields();
    end
    wr(8'h0d, 8'hff);
    chk_fields();
    for (int k = 0; k < 8; k++) begin
      wr(8'h0f, 8'(k * 73));
      wr(8'h0e, 8'(k * 16));
      chk_fields();
    end
    wr(8'h10, 8'hff);
    rd_chk(8'h10);
    $display("test field_codes done");
    wr(8'h0d, 8'h9a);
    wr(8'h0e, 8'h4f);
    wdog();
    all_regs();
    $display("test watchdog done");
    wr(8'h0f, 8'h00);
    wr(8'h12, 8'h7f);
    all_regs();
    wr(8'h10, 8'hcf);
    wr(8'h12, 8'h80);
    all_regs();
    $display("test soft_reset done");
    for (int n = 0; n < 60; n++) begin
      a = 8'h0c + 8'($unsigned($random(seed)) % 7);
      d = 8'($random(seed));
      wr(a, d);
      if (d[2:0] == 3'b101) wdog();
      rd_chk(a);
      chk_fields();
    end
    $display("test random done");
    // hardware reset in mid-run brings back every default
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (3) @(posedge clock);
    for (int i = 0; i < 5; i++) shadow[i] = rst_val(i);
    reset_n <= 1'b1;
    repeat (5) @(posedge clock);
    all_regs();
    $display("test mid_reset done");
    results();
  end
endmodule
`default_nettype wire
